// >>> icst_params.svh
// offsets, field positions, reset values and codes of the internal oscillator select block
`ifndef ICST_PARAMS_SVH
`define ICST_PARAMS_SVH

// register byte offsets
`define ICST_TRIM_OFS 8'h00
`define ICST_CTRL_OFS 8'h04
`define ICST_STAT_OFS 8'h08

// trim register fields
`define ICST_TRIM_LSB 0
`define ICST_TRIM_MSB 5
`define ICST_MULT_BIT 6
`define ICST_LFSS_BIT 7
`define ICST_TRIM_RST 8'h00

// control register fields
`define ICST_SCS_LSB 0
`define ICST_SCS_MSB 1
`define ICST_IFS_LSB 4
`define ICST_IFS_MSB 6
`define ICST_MOS_BIT 8
`define ICST_SCS_RST 2'h0
`define ICST_IFS_RST 3'h3
`define ICST_MOS_RST 1'h0

// primary clock configuration codes
`define ICST_CFG_RC_DIVIDED_CLOCK_OUTPUT 4'h3
`define ICST_CFG_RC_IO 4'h2
`define ICST_CFG_INT_IO 4'h8
`define ICST_CFG_INT_DIVIDED_CLOCK_OUTPUT 4'h9
`define ICST_CFG_INT_TOP 3'h4

// internal clock mux inputs
`define ICST_SRC_FAST_LOG2_512 4'h7
`define ICST_SRC_MED_DIV1 4'h8
`define ICST_SRC_MED_DIV2 4'h9
`define ICST_SRC_MED_DIV16 4'ha
`define ICST_SRC_SLOW 4'hb
`define ICST_SRC_COUNT 12

// system clock mux inputs
`define ICST_SYS_PRIMARY 2'h0
`define ICST_SYS_SECONDARY 2'h1
`define ICST_SYS_INTERNAL 2'h2

`endif

// >>> icst_pkg.sv
// types shared by the internal oscillator select block
package icst_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } icst_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } icst_wb_rsp_t;

    typedef struct packed {
        logic o;
        logic oe;
    } icst_pin_drv_t;

    typedef enum logic [1:0] {
        ICST_MUX_RUN = 2'b01,
        ICST_MUX_WAIT = 2'b10
    } icst_mux_state_t;

endpackage

// >>> icst_osc_div.sv
// synchroniser and binary ripple-free divider for one oscillator input
`timescale 1ns/1ps
module icst_osc_div #(
    parameter int WIDTH = 9
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // oscillator level from outside the domain
    input wire logic i_osc,
    // synchronised level and divided levels, bit k is the input over 2^(k+1)
    output logic o_level,
    output logic [WIDTH-1:0] o_div
);

    logic sync1_reg, sync1_next;
    logic sync2_reg, sync2_next;
    logic last_reg, last_next;
    logic [WIDTH-1:0] cnt_reg, cnt_next;

    always_comb begin
        sync1_next = i_osc;
        sync2_next = sync1_reg;
        last_next = sync2_reg;
        cnt_next = cnt_reg;
        if (sync2_reg && !last_reg) begin
            cnt_next = cnt_reg + WIDTH'(1'b1);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            last_reg <= last_next;
            cnt_reg <= cnt_next;
        end
    end

    assign o_level = sync2_reg;
    assign o_div = cnt_reg;

endmodule

// >>> icst_glitch_free_mux.sv
// clock level multiplexer that changes source only while both old and new are low
`timescale 1ns/1ps
module icst_glitch_free_mux #(
    parameter int N = 4,
    parameter int SW = 2,
    parameter logic [SW-1:0] RST_SEL = '0
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // candidate levels and requested selection
    input wire logic [N-1:0] i_src,
    input wire logic [SW-1:0] i_sel,
    // selected level and the selection in force
    output logic o_clk,
    output logic [SW-1:0] o_cur_sel
);

    icst_pkg::icst_mux_state_t state_reg, state_next;
    logic [SW-1:0] cur_reg, cur_next;
    logic out_reg, out_next;
    logic sel_ok;

    always_comb begin
        sel_ok = (int'(i_sel) < N);
        state_next = state_reg;
        cur_next = cur_reg;
        out_next = out_reg;
        case (state_reg)
            icst_pkg::ICST_MUX_RUN: begin
                out_next = i_src[cur_reg];
                if (sel_ok && i_sel != cur_reg) begin
                    state_next = icst_pkg::ICST_MUX_WAIT;
                    out_next = out_reg & i_src[cur_reg];
                end
            end
            icst_pkg::ICST_MUX_WAIT: begin
                // output may only fall here, so no high pulse is cut short
                out_next = out_reg & i_src[cur_reg];
                if (!sel_ok || i_sel == cur_reg) begin
                    state_next = icst_pkg::ICST_MUX_RUN;
                end else if (!out_reg && !i_src[i_sel]) begin
                    cur_next = i_sel;
                    state_next = icst_pkg::ICST_MUX_RUN;
                end
            end
            default: begin
                state_next = icst_pkg::ICST_MUX_RUN;
                out_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_reg <= icst_pkg::ICST_MUX_RUN;
            cur_reg <= RST_SEL;
            out_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            out_reg <= out_next;
        end
    end

    assign o_clk = out_reg;
    assign o_cur_sel = cur_reg;

endmodule

// >>> icst_internal_osc.sv
// internal oscillator selection, tuning and oscillator pin control
//
// What this block does
// - rc clock mode drives output pin with rc/4
// - rc pin mode frees output pin as gpio
// - two internal primary modes: gpio or fosc/4
// - internal primary modes make input pin gpio
// - trim is 6-bit signed, resets to zero
// - 011111 fastest, 100000 slowest, signed order
// - trim change drifts freely, no done flag
// - trim never touches the slow oscillator
// - low source bit picks divided or slow 31.25k
// - multiplier enable gates fast oscillator multiplier
// - multiplier only at select 110 and 111 in internal primary modes, else reads 0
// - eight internal frequencies, 1 MHz after reset
// - three oscillators, only fast two are trimmed
// - slow oscillator clocks timers and can be source
// - divider chain muxed onto one internal clock
// - software picks system clock source
// - select codes 111..011 divide fast by powers
// - substitute bit takes low rates from medium
`timescale 1ns/1ps
`include "icst_params.svh"
module icst_internal_osc #(
    parameter int FAST_DIV_W = 9,
    parameter int MED_DIV_W = 4
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // register bus
    input wire icst_pkg::icst_wb_req_t i_wb_req,
    output icst_pkg::icst_wb_rsp_t o_wb_rsp,
    // configuration bits
    input wire logic [3:0] i_primary_cfg,
    // oscillator levels
    input wire logic i_fast_osc,
    input wire logic i_medium_osc,
    input wire logic i_slow_osc,
    input wire logic i_secondary_osc,
    // crystal pins and port logic behind them
    input wire logic i_xin_pin,
    input wire logic i_xout_pin,
    input wire icst_pkg::icst_pin_drv_t i_port_xin_drv,
    input wire icst_pkg::icst_pin_drv_t i_port_xout_drv,
    output icst_pkg::icst_pin_drv_t o_xin_drv,
    output icst_pkg::icst_pin_drv_t o_xout_drv,
    output logic [1:0] o_gpio_in,
    // trim and multiplier controls to the oscillators
    output logic [5:0] o_fast_trim,
    output logic [5:0] o_medium_trim,
    output logic o_mult_en,
    // clocks out
    output logic o_int_clk,
    output logic o_sys_clk,
    output logic o_slow_timer_clk
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [3:0] int_src_sel(input logic [2:0] ifs, input logic lfss,
                                               input logic mos);
        logic [3:0] idx;
        idx = 4'h0;
        if (ifs >= 3'h3) begin
            idx = {1'b0, 3'h7 - ifs};
        end else if (mos) begin
            case (ifs)
                3'h2: idx = `ICST_SRC_MED_DIV1;
                3'h1: idx = `ICST_SRC_MED_DIV2;
                default: idx = lfss ? `ICST_SRC_MED_DIV16 : `ICST_SRC_SLOW;
            endcase
        end else begin
            case (ifs)
                3'h2: idx = 4'h5;
                3'h1: idx = 4'h6;
                default: idx = lfss ? `ICST_SRC_FAST_LOG2_512 : `ICST_SRC_SLOW;
            endcase
        end
        return idx;
    endfunction

    function automatic logic is_int_primary(input logic [3:0] cfg);
        return cfg[3:1] == `ICST_CFG_INT_TOP;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // oscillator dividers

    logic fast_lvl, med_lvl, slow_lvl, sec_lvl, xin_lvl;
    logic [FAST_DIV_W-1:0] fast_div;
    logic [MED_DIV_W-1:0] med_div;
    logic [1:0] xin_div;

    icst_osc_div #(.WIDTH(FAST_DIV_W)) u_fast_div (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_osc(i_fast_osc),
        .o_level(fast_lvl),
        .o_div(fast_div)
    );

    icst_osc_div #(.WIDTH(MED_DIV_W)) u_med_div (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_osc(i_medium_osc),
        .o_level(med_lvl),
        .o_div(med_div)
    );

    icst_osc_div #(.WIDTH(1)) u_slow_sync (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_osc(i_slow_osc),
        .o_level(slow_lvl),
        .o_div()
    );

    icst_osc_div #(.WIDTH(1)) u_sec_sync (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_osc(i_secondary_osc),
        .o_level(sec_lvl),
        .o_div()
    );

    // rc network or external clock on the input pin
    icst_osc_div #(.WIDTH(2)) u_xin_div (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_osc(i_xin_pin),
        .o_level(xin_lvl),
        .o_div(xin_div)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] trim_reg, trim_next;
    logic [1:0] scs_reg, scs_next;
    logic [2:0] ifs_reg, ifs_next;
    logic mos_reg, mos_next;
    icst_pkg::icst_wb_rsp_t rsp_reg, rsp_next;
    logic mult_allowed;
    logic [31:0] rd_data;
    logic take;

    assign mult_allowed = is_int_primary(i_primary_cfg) && (ifs_reg[2:1] == 2'b11);

    always_comb begin
        rd_data = 32'h0000_0000;
        case (i_wb_req.adr)
            `ICST_TRIM_OFS: begin
                rd_data[7:0] = trim_reg;
                rd_data[`ICST_MULT_BIT] = trim_reg[`ICST_MULT_BIT] & mult_allowed;
            end
            `ICST_CTRL_OFS: begin
                rd_data[`ICST_SCS_MSB:`ICST_SCS_LSB] = scs_reg;
                rd_data[`ICST_IFS_MSB:`ICST_IFS_LSB] = ifs_reg;
                rd_data[`ICST_MOS_BIT] = mos_reg;
            end
            `ICST_STAT_OFS: begin
                // no tuning-complete flag exists here
                rd_data[0] = o_int_clk;
                rd_data[1] = o_sys_clk;
                rd_data[5:2] = i_primary_cfg;
                rd_data[6] = o_mult_en;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_comb begin
        take = i_wb_req.cyc && i_wb_req.stb && !rsp_reg.ack;
        trim_next = trim_reg;
        scs_next = scs_reg;
        ifs_next = ifs_reg;
        mos_next = mos_reg;
        rsp_next.ack = take;
        rsp_next.dat = take ? rd_data : 32'h0000_0000;
        if (take && i_wb_req.we) begin
            if (i_wb_req.adr == `ICST_TRIM_OFS && i_wb_req.sel[0]) begin
                trim_next = i_wb_req.dat[7:0];
            end
            if (i_wb_req.adr == `ICST_CTRL_OFS) begin
                if (i_wb_req.sel[0]) begin
                    scs_next = i_wb_req.dat[`ICST_SCS_MSB:`ICST_SCS_LSB];
                    ifs_next = i_wb_req.dat[`ICST_IFS_MSB:`ICST_IFS_LSB];
                end
                if (i_wb_req.sel[1]) begin
                    mos_next = i_wb_req.dat[`ICST_MOS_BIT];
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            trim_reg <= `ICST_TRIM_RST;
            scs_reg <= `ICST_SCS_RST;
            ifs_reg <= `ICST_IFS_RST;
            mos_reg <= `ICST_MOS_RST;
            rsp_reg <= '0;
        end else begin
            trim_reg <= trim_next;
            scs_reg <= scs_next;
            ifs_reg <= ifs_next;
            mos_reg <= mos_next;
            rsp_reg <= rsp_next;
        end
    end

    assign o_wb_rsp = rsp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // internal and system clock selection

    logic [`ICST_SRC_COUNT-1:0] int_srcs;
    logic [3:0] int_sel;
    logic int_clk;
    logic sys_clk;
    logic [2:0] sys_srcs;
    logic [1:0] sys_sel;

    always_comb begin
        int_srcs = '0;
        int_srcs[0] = fast_lvl;
        for (int k = 1; k < 7; k++) begin
            int_srcs[k] = fast_div[k-1];
        end
        int_srcs[`ICST_SRC_FAST_LOG2_512] = fast_div[8];
        int_srcs[`ICST_SRC_MED_DIV1] = med_lvl;
        int_srcs[`ICST_SRC_MED_DIV2] = med_div[0];
        int_srcs[`ICST_SRC_MED_DIV16] = med_div[3];
        int_srcs[`ICST_SRC_SLOW] = slow_lvl;
    end

    assign int_sel = int_src_sel(ifs_reg, trim_reg[`ICST_LFSS_BIT], mos_reg);

    icst_glitch_free_mux #(.N(`ICST_SRC_COUNT), .SW(4), .RST_SEL(4'h4)) u_int_mux (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_src(int_srcs),
        .i_sel(int_sel),
        .o_clk(int_clk),
        .o_cur_sel()
    );

    always_comb begin
        sys_srcs[`ICST_SYS_PRIMARY] = is_int_primary(i_primary_cfg) ? int_clk : xin_lvl;
        sys_srcs[`ICST_SYS_SECONDARY] = sec_lvl;
        sys_srcs[`ICST_SYS_INTERNAL] = int_clk;
        sys_sel = scs_reg[1] ? `ICST_SYS_INTERNAL : scs_reg;
    end

    icst_glitch_free_mux #(.N(3), .SW(2), .RST_SEL(2'h0)) u_sys_mux (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_src(sys_srcs),
        .i_sel(sys_sel),
        .o_clk(sys_clk),
        .o_cur_sel()
    );

    assign o_int_clk = int_clk;
    assign o_sys_clk = sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    // fosc/4, pins and oscillator controls

    logic sys_last_reg, sys_last_next;
    logic [1:0] q_cnt_reg, q_cnt_next;
    logic xo_s1_reg, xo_s2_reg;
    logic xi_s1_reg, xi_s2_reg;
    icst_pkg::icst_pin_drv_t xin_drv_reg, xin_drv_next;
    icst_pkg::icst_pin_drv_t xout_drv_reg, xout_drv_next;
    logic [5:0] trim_out_reg, trim_out_next;
    logic mult_reg, mult_next;
    logic slow_out_reg, slow_out_next;

    always_comb begin
        sys_last_next = sys_clk;
        q_cnt_next = q_cnt_reg;
        if (sys_clk && !sys_last_reg) begin
            q_cnt_next = q_cnt_reg + 2'h1;
        end
        xin_drv_next = '0;
        xout_drv_next = '0;
        if (is_int_primary(i_primary_cfg)) begin
            xin_drv_next = i_port_xin_drv;
        end
        case (i_primary_cfg)
            `ICST_CFG_RC_DIVIDED_CLOCK_OUTPUT: begin
                xout_drv_next.o = xin_div[1];
                xout_drv_next.oe = 1'b1;
            end
            `ICST_CFG_RC_IO: xout_drv_next = i_port_xout_drv;
            `ICST_CFG_INT_IO: xout_drv_next = i_port_xout_drv;
            `ICST_CFG_INT_DIVIDED_CLOCK_OUTPUT: begin
                xout_drv_next.o = q_cnt_reg[1];
                xout_drv_next.oe = 1'b1;
            end
            default: xout_drv_next = '0;
        endcase
        // trim goes only to the fast and medium oscillators, never the slow one
        trim_out_next = trim_reg[`ICST_TRIM_MSB:`ICST_TRIM_LSB];
        mult_next = trim_reg[`ICST_MULT_BIT] & mult_allowed;
        slow_out_next = slow_lvl;
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sys_last_reg <= 1'b0;
            q_cnt_reg <= 2'h0;
            xo_s1_reg <= 1'b0;
            xo_s2_reg <= 1'b0;
            xi_s1_reg <= 1'b0;
            xi_s2_reg <= 1'b0;
            xin_drv_reg <= '0;
            xout_drv_reg <= '0;
            trim_out_reg <= 6'h00;
            mult_reg <= 1'b0;
            slow_out_reg <= 1'b0;
        end else begin
            sys_last_reg <= sys_last_next;
            q_cnt_reg <= q_cnt_next;
            xo_s1_reg <= i_xout_pin;
            xo_s2_reg <= xo_s1_reg;
            xi_s1_reg <= i_xin_pin;
            xi_s2_reg <= xi_s1_reg;
            xin_drv_reg <= xin_drv_next;
            xout_drv_reg <= xout_drv_next;
            trim_out_reg <= trim_out_next;
            mult_reg <= mult_next;
            slow_out_reg <= slow_out_next;
        end
    end

    assign o_xin_drv = xin_drv_reg;
    assign o_xout_drv = xout_drv_reg;
    assign o_gpio_in = {xo_s2_reg, xi_s2_reg};
    assign o_fast_trim = trim_out_reg;
    assign o_medium_trim = trim_out_reg;
    assign o_mult_en = mult_reg;
    assign o_slow_timer_clk = slow_out_reg;

endmodule

// >>> icst_internal_osc_monitor.sv
// assertion checker for the internal oscillator select block
`timescale 1ns/1ps
`include "icst_params.svh"
module icst_internal_osc_monitor (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // bus, configuration and port requests
    input wire icst_pkg::icst_wb_req_t i_wb_req,
    input wire icst_pkg::icst_wb_rsp_t o_wb_rsp,
    input wire logic [3:0] i_primary_cfg,
    input wire icst_pkg::icst_pin_drv_t i_port_xin_drv,
    input wire icst_pkg::icst_pin_drv_t i_port_xout_drv,
    // watched outputs
    input wire icst_pkg::icst_pin_drv_t o_xin_drv,
    input wire icst_pkg::icst_pin_drv_t o_xout_drv,
    input wire logic [5:0] o_fast_trim,
    input wire logic [5:0] o_medium_trim,
    input wire logic o_mult_en
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////
    a_ack_once: assert property (o_wb_rsp.ack |=> !o_wb_rsp.ack)
        else $error("ack held longer than one cycle");
    a_ack_next: assert property (i_wb_req.cyc && i_wb_req.stb && !o_wb_rsp.ack
        && !$past(o_wb_rsp.ack) |=> o_wb_rsp.ack) else $error("ack not one cycle after request");
    a_dat_idle: assert property (!o_wb_rsp.ack |-> o_wb_rsp.dat == 32'h0)
        else $error("read data not zero outside ack");
    a_rc_divided_clock_output: assert property (i_primary_cfg == `ICST_CFG_RC_DIVIDED_CLOCK_OUTPUT
        && $stable(i_primary_cfg) |=> o_xout_drv.oe) else $error("rc mode output pin not driven");
    a_resistor_capacitor_pin_mode_free: assert property (i_primary_cfg == `ICST_CFG_RC_IO && $stable(i_primary_cfg)
        |=> o_xout_drv == $past(i_port_xout_drv)) else $error("rc pin mode output not port");
    a_int_xout_io: assert property (i_primary_cfg == `ICST_CFG_INT_IO
        && $stable(i_primary_cfg) |=> o_xout_drv == $past(i_port_xout_drv))
        else $error("internal io mode output not port");
    a_int_divided_clock_output: assert property (i_primary_cfg == `ICST_CFG_INT_DIVIDED_CLOCK_OUTPUT
        && $stable(i_primary_cfg) |=> o_xout_drv.oe) else $error("internal divided_clock_output not driven");
    a_xin_port: assert property (i_primary_cfg[3:1] == `ICST_CFG_INT_TOP
        && $stable(i_primary_cfg) |=> o_xin_drv == $past(i_port_xin_drv))
        else $error("input pin not port in internal mode");
    a_mult_gate: assert property (o_mult_en |-> $past(i_primary_cfg[3:1]) == `ICST_CFG_INT_TOP)
        else $error("multiplier on outside internal primary");
    a_trim_pair: assert property ($past(o_wb_rsp.ack && i_wb_req.we
        && i_wb_req.adr == `ICST_TRIM_OFS && i_wb_req.sel[0]) |-> o_fast_trim == o_medium_trim
        && o_fast_trim == $past(i_wb_req.dat[5:0]))
        else $error("trims do not follow a write");
    a_reset_clear: assert property (disable iff (1'b0) i_sys_rst |=> o_fast_trim == 6'h00
        && !o_mult_en && !o_wb_rsp.ack) else $error("outputs not cleared by reset");
    ////////////////////////////////////////////////////////////
    c_mult_on: cover property (o_mult_en);
    c_write: cover property (o_wb_rsp.ack && i_wb_req.we);
    c_rc_out: cover property (o_xout_drv.oe && i_primary_cfg == `ICST_CFG_RC_DIVIDED_CLOCK_OUTPUT);
endmodule

// >>> icst_osc_model.sv
// free running oscillators and rc network feeding the block
`timescale 1ns/1ps
module icst_osc_model #(
    parameter int FAST_HALF = 40,
    parameter int MED_HALF = 400,
    parameter int SLOW_HALF = 300,
    parameter int SEC_HALF = 100,
    parameter int RC_HALF = 60
) (
    // oscillator levels
    output logic o_fast_osc,
    output logic o_medium_osc,
    output logic o_slow_osc,
    output logic o_secondary_osc,
    // rc network level at the crystal input pin
    output logic o_rc_osc
);
    // edges sit on multiples of 4 ns, away from the bench clock edges at 2 mod 4
    initial begin
        o_fast_osc = 1'b0;
        forever #(FAST_HALF) o_fast_osc = ~o_fast_osc;
    end
    initial begin
        o_medium_osc = 1'b0;
        forever #(MED_HALF) o_medium_osc = ~o_medium_osc;
    end
    // slow one has no trim input at all, so trim writes cannot move it
    initial begin
        o_slow_osc = 1'b0;
        forever #(SLOW_HALF) o_slow_osc = ~o_slow_osc;
    end
    initial begin
        o_secondary_osc = 1'b0;
        forever #(SEC_HALF) o_secondary_osc = ~o_secondary_osc;
    end
    initial begin
        o_rc_osc = 1'b0;
        forever #(RC_HALF) o_rc_osc = ~o_rc_osc;
    end
endmodule

// >>> icst_internal_osc_tb.sv
// self-checking testbench for the internal oscillator select block
`timescale 1ns/1ps
`include "icst_params.svh"
module icst_internal_osc_tb;
    // periods in bench cycles, twice the model half periods over 4 ns
    localparam int FP = 20;
    localparam int MP = 200;
    localparam int SP = 150;
    localparam int CP = 50;
    localparam int RP = 30;
    logic clk, rst, fast, med, slow, sec, rc, xin_pin, xout_pin, mon;
    logic mult, int_clk, sys_clk, slow_clk;
    logic [3:0] cfg;
    logic [1:0] gpio_in;
    logic [5:0] ftrim, mtrim;
    logic [31:0] rd;
    icst_pkg::icst_wb_req_t req;
    icst_pkg::icst_wb_rsp_t rsp;
    icst_pkg::icst_pin_drv_t port_xin, port_xout, xin_drv, xout_drv;
    int msel, err_total, n_checks;
    int codes[13] = '{7, 6, 5, 4, 3, 2, 1, 0, 16, 10, 9, 8, 24};
    // released output pin rests on its pull-up
    assign xin_pin = xin_drv.oe ? xin_drv.o : rc;
    assign xout_pin = xout_drv.oe ? xout_drv.o : 1'b1;
    assign mon = msel == 0 ? int_clk : msel == 1 ? sys_clk : msel == 2 ? slow_clk : xout_drv.o;
    icst_osc_model u_osc (.o_fast_osc(fast), .o_medium_osc(med), .o_slow_osc(slow),
        .o_secondary_osc(sec), .o_rc_osc(rc));
    icst_internal_osc uut (.i_mclk(clk), .i_sys_rst(rst), .i_wb_req(req), .o_wb_rsp(rsp),
        .i_primary_cfg(cfg), .i_fast_osc(fast), .i_medium_osc(med), .i_slow_osc(slow),
        .i_secondary_osc(sec), .i_xin_pin(xin_pin), .i_xout_pin(xout_pin),
        .i_port_xin_drv(port_xin), .i_port_xout_drv(port_xout), .o_xin_drv(xin_drv),
        .o_xout_drv(xout_drv), .o_gpio_in(gpio_in), .o_fast_trim(ftrim),
        .o_medium_trim(mtrim), .o_mult_en(mult), .o_int_clk(int_clk), .o_sys_clk(sys_clk),
        .o_slow_timer_clk(slow_clk));
    ////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, e, g);
        end
    endtask
    // entered just after an edge; holds the request until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, we, adr, 4'hf, wd};
        do begin
            @(posedge clk);
            n++;
        end while (rsp.ack !== 1'b1);
        chk("ack cycles", 32'h2, 32'(n));
        rd = rsp.dat;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic setc(input logic m, input logic [2:0] f, input logic [1:0] s);
        wb(1'b1, `ICST_CTRL_OFS, {23'h0, m, 1'b0, f, 2'h0, s});
    endtask
    task automatic rise(output int n);
        logic p;
        n = 0;
        do begin
            p = mon;
            @(posedge clk);
            n++;
        end while (!(p === 1'b0 && mon === 1'b1) && n < 12000);
    endtask
    // first rise may belong to the old source, so only the third span counts
    task automatic per(input int s, input int e, input string name);
        int n;
        msel = s;
        rise(n);
        rise(n);
        rise(n);
        n_checks++;
        if (n > e + 2 || n < e - 2) begin
            err_total++;
            $display("unexpected %s period: expected %0d seen %0d", name, e, n);
        end
    endtask
    function automatic int exp_per(input int l, input int m, input int f);
        if (f >= 3 || (m == 0 && f != 0)) return FP << (7 - f);
        if (f == 0 && l == 0) return SP;
        if (f == 0) return m != 0 ? MP * 16 : FP * 512;
        return MP << (2 - f);
    endfunction
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        $display("unexpected run length: expected end seen timeout");
        stop_test();
    end
    initial begin
        rst = 1'b1;
        req = '0;
        cfg = `ICST_CFG_INT_IO;
        port_xin = '{1'b1, 1'b1};
        port_xout = '{1'b0, 1'b1};
        msel = 0;
        err_total = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b1, 8'h0c, 32'hff);
        wb(1'b0, 8'h0c, 32'h0);
        chk("unmapped read", 32'h0, rd);
        wb(1'b0, `ICST_TRIM_OFS, 32'h0);
        chk("trim reg", 32'(`ICST_TRIM_RST), rd);
        chk("fast trim", 32'h0, 32'(ftrim));
        wb(1'b0, `ICST_CTRL_OFS, 32'h0);
        chk("ctrl reg", 32'(`ICST_IFS_RST) << `ICST_IFS_LSB, rd);
        wb(1'b1, `ICST_TRIM_OFS, 32'h1f);
        chk("fast trim", 32'h1f, 32'(ftrim));
        chk("medium trim", 32'h1f, 32'(mtrim));
        wb(1'b1, `ICST_TRIM_OFS, 32'h20);
        wb(1'b0, `ICST_TRIM_OFS, 32'h0);
        chk("trim reg", 32'h20, rd);
        per(2, SP, "slow timer");
        foreach (codes[i]) begin
            wb(1'b1, `ICST_TRIM_OFS, 32'(codes[i] >> 4) << `ICST_LFSS_BIT);
            setc(1'((codes[i] >> 3) & 1), 3'(codes[i] & 7), 2'h2);
            per(0, exp_per(codes[i] >> 4, (codes[i] >> 3) & 1, codes[i] & 7), "int clk");
        end
        setc(1'b0, 3'h7, 2'h2);
        per(1, FP, "sys clk internal");
        setc(1'b0, 3'h7, 2'h1);
        per(1, CP, "sys clk secondary");
        wb(1'b1, `ICST_TRIM_OFS, 32'h40);
        wb(1'b0, `ICST_TRIM_OFS, 32'h0);
        chk("trim reg", 32'h40, rd);
        chk("mult", 32'h1, 32'(mult));
        setc(1'b0, 3'h6, 2'h1);
        chk("mult", 32'h1, 32'(mult));
        setc(1'b0, 3'h5, 2'h1);
        wb(1'b0, `ICST_TRIM_OFS, 32'h0);
        chk("trim reg", 32'h0, rd);
        chk("mult", 32'h0, 32'(mult));
        setc(1'b0, 3'h7, 2'h0);
        cfg <= `ICST_CFG_RC_IO;
        repeat (8) @(posedge clk);
        chk("mult", 32'h0, 32'(mult));
        chk("xout drive", 32'(port_xout), 32'(xout_drv));
        chk("xin oe", 32'h0, 32'(xin_drv.oe));
        chk("gpio in", 32'h0, 32'(gpio_in[1]));
        cfg <= `ICST_CFG_RC_DIVIDED_CLOCK_OUTPUT;
        repeat (2) @(posedge clk);
        chk("xout oe", 32'h1, 32'(xout_drv.oe));
        per(3, 4 * RP, "rc divided_clock_output");
        cfg <= `ICST_CFG_INT_DIVIDED_CLOCK_OUTPUT;
        repeat (2) @(posedge clk);
        chk("xin drive", 32'(port_xin), 32'(xin_drv));
        per(3, 4 * FP, "fosc divided_clock_output");
        cfg <= `ICST_CFG_INT_IO;
        port_xout <= '{1'b1, 1'b1};
        repeat (2) @(posedge clk);
        chk("xout drive", 32'(port_xout), 32'(xout_drv));
        chk("xin drive", 32'(port_xin), 32'(xin_drv));
        chk("gpio in", 32'h1, 32'(gpio_in[0]));
        chk("mult", 32'h1, 32'(mult));
        wb(1'b0, `ICST_STAT_OFS, 32'h0);
        chk("status", 32'h60, rd & 32'hffff_fffc);
        stop_test();
    end
endmodule

bind icst_internal_osc icst_internal_osc_monitor u_mon (.i_mclk, .i_sys_rst, .i_wb_req,
    .o_wb_rsp, .i_primary_cfg, .i_port_xin_drv, .i_port_xout_drv, .o_xin_drv, .o_xout_drv,
    .o_fast_trim, .o_medium_trim, .o_mult_en);
